// ===== logic/irpm_pkg.sv
package irpm_pkg;
	// -------------------------------------------------------------------------
	// register spaces and offsets
	// -------------------------------------------------------------------------
	localparam logic SPACE_DATA = 1'b0; // data-space registers
	localparam logic SPACE_CTRL = 1'b1; // control-space registers
	localparam logic [3:0] OFS_PULSE_COUNT_LOW = 4'h6;
	localparam logic [3:0] OFS_PULSE_COUNT_HIGH = 4'h7;
	localparam logic [3:0] OFS_COUNTER_CONTROL = 4'h8;
	localparam logic [3:0] OFS_LOW_PHASE_LENGTH = 4'h9;
	localparam logic [3:0] OFS_HIGH_PHASE_LENGTH = 4'ha;
	localparam logic [3:0] OFS_PULSE_TIMER_VALUE = 4'hb;
	localparam logic [3:0] OFS_COUNTER_STATUS_ENABLES = 4'hb;
	localparam logic [3:0] OFS_MODULATOR_CONTROL = 4'hd;
	localparam logic [3:0] OFS_BURST_FLAG = 4'hf;

	// -------------------------------------------------------------------------
	// field positions, masks and reset values
	// -------------------------------------------------------------------------
	localparam int BIT_BURST_IRQ_ENABLE = 6;
	localparam int BIT_UPPER_BYTE_ENABLE = 4;
	localparam int BIT_DUTY_RATIO_LO = 6;
	localparam int BIT_CARRIER_DIV_LO = 4;
	localparam int BIT_MODULATOR_ENABLE = 3;
	localparam int BIT_CARRIER_MODULATE = 2;
	localparam int BIT_LONG_PULSE_SELECT = 1;
	localparam int BIT_CONTINUOUS = 0;
	localparam int BIT_BURST_DONE_FLAG = 0;
	localparam logic [7:0] MASK_COUNTER_STATUS = 8'h77;
	localparam logic [7:0] MASK_COUNTER_CONTROL = 8'hf0;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// -------------------------------------------------------------------------
	// modulation clock and duty codes
	// -------------------------------------------------------------------------
	localparam logic [1:0] DIV_BY1 = 2'h0;
	localparam logic [1:0] DIV_BY4 = 2'h2;
	localparam logic [1:0] DIV_BY8 = 2'h3;
	localparam logic [3:0] DIV_COUNT_1 = 4'h1;
	localparam logic [3:0] DIV_COUNT_4 = 4'h4;
	localparam logic [3:0] DIV_COUNT_8 = 4'h8;
	localparam logic [1:0] DUTY_1_2 = 2'h0;
	localparam logic [1:0] DUTY_1_3 = 2'h1;
	localparam logic [1:0] DUTY_1_4 = 2'h2;
	localparam logic [2:0] DUTY_DEN_2 = 3'h2;
	localparam logic [2:0] DUTY_DEN_3 = 3'h3;
	localparam logic [2:0] DUTY_DEN_4 = 3'h4;

	typedef enum logic [3:0] {
		IRPM_IDLE = 4'b0001,
		IRPM_LOW = 4'b0010,
		IRPM_HIGH = 4'b0100,
		IRPM_DONE = 4'b1000
	} irpm_state_t;

	// core cycles per modulation-clock tick; undefined code acts as divide by one
	function automatic logic [3:0] irpm_div_count(input logic [1:0] sel);
		unique case (sel)
			DIV_BY4: irpm_div_count = DIV_COUNT_4;
			DIV_BY8: irpm_div_count = DIV_COUNT_8;
			default: irpm_div_count = DIV_COUNT_1;
		endcase
	endfunction

	// ticks per carrier period; undefined code acts as 1:2
	function automatic logic [2:0] irpm_duty_den(input logic [1:0] sel);
		unique case (sel)
			DUTY_1_3: irpm_duty_den = DUTY_DEN_3;
			DUTY_1_4: irpm_duty_den = DUTY_DEN_4;
			default: irpm_duty_den = DUTY_DEN_2;
		endcase
	endfunction
endpackage

// ===== logic/irpm_carrier.sv
`timescale 1ns/1ns
module irpm_carrier
	import irpm_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic run_in,
	input wire logic [1:0] div_sel_in,
	input wire logic [1:0] duty_sel_in,
	output logic tick_out,
	output logic carrier_on_out
);
	logic [3:0] div_cnt_r;
	logic [2:0] phase_r;
	logic [3:0] div_n;
	logic [2:0] den_n;

	assign div_n = irpm_div_count(div_sel_in);
	assign den_n = irpm_duty_den(duty_sel_in);

	// -------------------------------------------------------------------------
	// modulation clock enable
	// -------------------------------------------------------------------------
	// divider is preloaded while idle so the first tick lands one full period after start;
	// a plain restart would stretch the first phase of every burst by a cycle
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			div_cnt_r <= 4'h0;
			tick_out <= 1'b0;
		end else if (!run_in) begin
			div_cnt_r <= 4'h1;
			tick_out <= (div_n == DIV_COUNT_1);
		end else if (div_cnt_r >= div_n - 4'h1) begin
			div_cnt_r <= 4'h0;
			tick_out <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 4'h1;
			tick_out <= 1'b0;
		end
	end

	// carrier: on for one tick out of each duty period
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in || !run_in) begin
			phase_r <= 3'h0;
			carrier_on_out <= 1'b1;
		end else if (tick_out) begin
			phase_r <= (phase_r >= den_n - 3'h1) ? 3'h0 : phase_r + 3'h1;
			carrier_on_out <= (phase_r >= den_n - 3'h1);
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	undef_div_a: assert property ((run_in && div_sel_in == 2'h1) |-> div_n == DIV_COUNT_1)
		else $error("undefined modulation clock code not treated as divide by one");
	tick_space_a: assert property ((tick_out && run_in && div_sel_in == DIV_BY4
		&& $stable(div_sel_in)) |=> !tick_out [*3])
		else $error("modulation tick too early at divide by four");
endmodule // irpm_carrier

// ===== logic/irpm_modulator.sv
`timescale 1ns/1ns
// Contract
// - low phase lasts low-length ticks
// - high phase lasts high-length ticks
// - timer reloads alternately, counts down per tick
// - count low byte readable, writable, reset-cleared
// - count high byte readable, writable, reset-cleared
// - status bit 6 gates burst interrupt
// - control bit 4 enables count upper byte
// - bits 7:6 select duty ratio
// - bits 5:4 select modulation clock divider
// - enable low disables modulator entirely
// - enable high ignores trigger bits, counts down
// - carrier bit modulates each low phase
// - long pulse ignores high-length, one pulse
// - long pulse carrier-modulated when carrier set
// - continuous mode: endless train, count unused
// - train drives port six bit seven
// - low byte write starts burst, output low
// - count decrements per low; zero ends burst
module irpm_modulator
	import irpm_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic reg_space_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic port6_bit7_out,
	output logic burst_irq_out
);
	// -------------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------------
	logic [7:0] pulse_count_low_r;
	logic [7:0] pulse_count_high_r;
	logic [7:0] counter_control_r;
	logic [7:0] low_phase_length_r;
	logic [7:0] high_phase_length_r;
	logic [7:0] counter_status_enables_r;
	logic [7:0] modulator_control_r;
	logic [7:0] pulse_timer_value_r;
	logic burst_done_flag_r;
	logic enable_d_r;
	irpm_state_t state_r;

	logic wr_data_space;
	logic wr_ctrl_space;
	logic wr_count_low;
	logic wr_count_high;
	logic modulator_enable;
	logic carrier_modulate;
	logic long_pulse_select;
	logic continuous;
	logic upper_byte_enable;
	logic burst_irq_enable;
	logic mod_tick;
	logic carrier_on;
	logic run;
	logic [15:0] pulse_counter_16bit;
	logic [15:0] count_dec;
	logic phase_end;
	logic low_end;
	logic burst_end;
	logic start;

	assign wr_data_space = reg_wr_in && reg_space_in == SPACE_DATA;
	assign wr_ctrl_space = reg_wr_in && reg_space_in == SPACE_CTRL;
	assign wr_count_low = wr_ctrl_space && reg_addr_in == OFS_PULSE_COUNT_LOW;
	assign wr_count_high = wr_ctrl_space && reg_addr_in == OFS_PULSE_COUNT_HIGH;

	assign modulator_enable = modulator_control_r[BIT_MODULATOR_ENABLE];
	assign carrier_modulate = modulator_control_r[BIT_CARRIER_MODULATE];
	assign long_pulse_select = modulator_control_r[BIT_LONG_PULSE_SELECT];
	assign continuous = modulator_control_r[BIT_CONTINUOUS] && !long_pulse_select;
	assign upper_byte_enable = counter_control_r[BIT_UPPER_BYTE_ENABLE];
	assign burst_irq_enable = counter_status_enables_r[BIT_BURST_IRQ_ENABLE];

	// -------------------------------------------------------------------------
	// burst sequencing terms
	// -------------------------------------------------------------------------
	// upper byte counts only when enabled; otherwise the burst is the low byte alone
	assign pulse_counter_16bit = upper_byte_enable ? {pulse_count_high_r, pulse_count_low_r}
		: {8'h00, pulse_count_low_r};
	assign count_dec = pulse_counter_16bit - 16'h0001;
	assign run = state_r == IRPM_LOW || state_r == IRPM_HIGH;
	assign phase_end = run && mod_tick && pulse_timer_value_r <= 8'h01;
	assign low_end = phase_end && state_r == IRPM_LOW;
	// a burst that reaches zero ends; continuous mode never counts
	assign burst_end = low_end && !continuous && count_dec == 16'h0000;
	// trigger-source and edge bits are never consulted here
	assign start = modulator_enable && state_r == IRPM_IDLE
		&& (wr_count_low || (!enable_d_r && pulse_counter_16bit != 16'h0000));

	irpm_carrier u_carrier (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.run_in(run),
		.div_sel_in(modulator_control_r[BIT_CARRIER_DIV_LO +: 2]),
		.duty_sel_in(modulator_control_r[BIT_DUTY_RATIO_LO +: 2]),
		.tick_out(mod_tick),
		.carrier_on_out(carrier_on)
	);

	// -------------------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			counter_control_r <= RST_BYTE;
			low_phase_length_r <= RST_BYTE;
			high_phase_length_r <= RST_BYTE;
			counter_status_enables_r <= RST_BYTE;
			modulator_control_r <= RST_BYTE;
		end else begin
			if (wr_ctrl_space && reg_addr_in == OFS_COUNTER_CONTROL)
				counter_control_r <= reg_wdata_in & MASK_COUNTER_CONTROL;
			if (wr_ctrl_space && reg_addr_in == OFS_LOW_PHASE_LENGTH)
				low_phase_length_r <= reg_wdata_in;
			if (wr_ctrl_space && reg_addr_in == OFS_HIGH_PHASE_LENGTH)
				high_phase_length_r <= reg_wdata_in;
			if (wr_data_space && reg_addr_in == OFS_COUNTER_STATUS_ENABLES)
				counter_status_enables_r <= reg_wdata_in & MASK_COUNTER_STATUS;
			if (wr_data_space && reg_addr_in == OFS_MODULATOR_CONTROL)
				modulator_control_r <= reg_wdata_in;
		end
	end

	// -------------------------------------------------------------------------
	// pulse count bytes
	// -------------------------------------------------------------------------
	// a software write in the same cycle as a decrement takes precedence
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			pulse_count_low_r <= RST_BYTE;
			pulse_count_high_r <= RST_BYTE;
		end else begin
			if (wr_count_low)
				pulse_count_low_r <= reg_wdata_in;
			else if (low_end && !continuous)
				pulse_count_low_r <= count_dec[7:0];
			if (wr_count_high)
				pulse_count_high_r <= reg_wdata_in;
			else if (low_end && !continuous && upper_byte_enable)
				pulse_count_high_r <= count_dec[15:8];
		end
	end

	// -------------------------------------------------------------------------
	// sequencer and pulse timer
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			state_r <= IRPM_IDLE;
			pulse_timer_value_r <= RST_BYTE;
			enable_d_r <= 1'b0;
		end else begin
			enable_d_r <= modulator_enable;
			if (!modulator_enable) begin
				state_r <= IRPM_IDLE;
			end else begin
				unique case (state_r)
					IRPM_IDLE: begin
						if (start) begin
							state_r <= IRPM_LOW;
							pulse_timer_value_r <= low_phase_length_r;
						end
					end
					IRPM_LOW: begin
						if (burst_end) begin
							state_r <= IRPM_DONE;
						end else if (low_end && long_pulse_select) begin
							pulse_timer_value_r <= low_phase_length_r;
						end else if (low_end) begin
							state_r <= IRPM_HIGH;
							pulse_timer_value_r <= high_phase_length_r;
						end else if (mod_tick) begin
							pulse_timer_value_r <= pulse_timer_value_r - 8'h01;
						end
					end
					IRPM_HIGH: begin
						if (phase_end) begin
							state_r <= IRPM_LOW;
							pulse_timer_value_r <= low_phase_length_r;
						end else if (mod_tick) begin
							pulse_timer_value_r <= pulse_timer_value_r - 8'h01;
						end
					end
					IRPM_DONE: begin
						// only a disable leaves a finished burst
						state_r <= IRPM_DONE;
					end
				endcase
			end
		end
	end

	// -------------------------------------------------------------------------
	// completion flag, interrupt and output pin
	// -------------------------------------------------------------------------
	// software clears by writing zero to the flag bit; a new completion wins
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			burst_done_flag_r <= 1'b0;
		end else if (burst_end) begin
			burst_done_flag_r <= 1'b1;
		end else if (wr_data_space && reg_addr_in == OFS_BURST_FLAG
			&& !reg_wdata_in[BIT_BURST_DONE_FLAG]) begin
			burst_done_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			burst_irq_out <= 1'b0;
		end else begin
			burst_irq_out <= burst_done_flag_r && burst_irq_enable;
		end
	end

	// active low; carrier chops the low phase, including a long pulse
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			port6_bit7_out <= 1'b1;
		end else begin
			port6_bit7_out <= !(state_r == IRPM_LOW
				&& (!carrier_modulate || carrier_on));
		end
	end

	// -------------------------------------------------------------------------
	// read path
	// -------------------------------------------------------------------------
	// answer one cycle after the address; unmapped offsets read zero
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_space_in == SPACE_CTRL) begin
			unique case (reg_addr_in)
				OFS_PULSE_COUNT_LOW: reg_rdata_out <= pulse_count_low_r;
				OFS_PULSE_COUNT_HIGH: reg_rdata_out <= pulse_count_high_r;
				OFS_COUNTER_CONTROL: reg_rdata_out <= counter_control_r;
				OFS_LOW_PHASE_LENGTH: reg_rdata_out <= low_phase_length_r;
				OFS_HIGH_PHASE_LENGTH: reg_rdata_out <= high_phase_length_r;
				OFS_PULSE_TIMER_VALUE: reg_rdata_out <= pulse_timer_value_r;
				default: reg_rdata_out <= 8'h00;
			endcase
		end else begin
			unique case (reg_addr_in)
				OFS_COUNTER_STATUS_ENABLES: reg_rdata_out <= counter_status_enables_r;
				OFS_MODULATOR_CONTROL: reg_rdata_out <= modulator_control_r;
				OFS_BURST_FLAG: reg_rdata_out <= {7'h00, burst_done_flag_r};
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	start_low_a: assert property (start |=> ##1 !port6_bit7_out
		|| carrier_modulate || !modulator_enable)
		else $error("output not low after burst start");
	start_load_a: assert property (start |=> pulse_timer_value_r == $past(low_phase_length_r))
		else $error("timer not loaded with low length at start");
	timer_step_a: assert property ((run && mod_tick && pulse_timer_value_r > 8'h01
		&& modulator_enable) |=> pulse_timer_value_r == $past(pulse_timer_value_r) - 8'h01)
		else $error("pulse timer did not count down by one");
	low_to_high_a: assert property ((low_end && !burst_end && !long_pulse_select
		&& modulator_enable) |=> state_r == IRPM_HIGH
		&& pulse_timer_value_r == $past(high_phase_length_r))
		else $error("low phase did not hand over to high phase");
	high_to_low_a: assert property ((phase_end && state_r == IRPM_HIGH && modulator_enable)
		|=> state_r == IRPM_LOW && pulse_timer_value_r == $past(low_phase_length_r))
		else $error("high phase did not hand over to low phase");
	long_stays_a: assert property ((low_end && long_pulse_select && !burst_end
		&& modulator_enable) |=> state_r == IRPM_LOW)
		else $error("long pulse left the low phase early");
	count_step_a: assert property ((low_end && !continuous && !wr_count_low
		&& modulator_enable) |=> pulse_count_low_r == $past(count_dec[7:0]))
		else $error("pulse count did not decrement at end of low phase");
	cont_hold_a: assert property ((low_end && continuous && !wr_count_low
		&& !wr_count_high) |=> $stable(pulse_count_low_r) && state_r != IRPM_DONE)
		else $error("continuous mode touched the pulse count");
	burst_flag_a: assert property ((burst_end && modulator_enable) |=> burst_done_flag_r
		&& state_r == IRPM_DONE ##2 port6_bit7_out)
		else $error("burst end did not raise flag and stop");
	irq_gate_a: assert property (##1 burst_irq_out == $past(burst_done_flag_r && burst_irq_enable))
		else $error("interrupt output not gated by enable bit");
	disable_idle_a: assert property (!modulator_enable |=> state_r == IRPM_IDLE ##1 port6_bit7_out)
		else $error("disabled modulator still active");
	idle_high_a: assert property ((state_r == IRPM_IDLE || state_r == IRPM_DONE)
		|=> port6_bit7_out)
		else $error("output not high while stopped");

	// -------------------------------------------------------------------------
	// reset, counting and pin checks
	// -------------------------------------------------------------------------
	// these look through reset on purpose, so the default disable is overridden
	count_low_rst_a: assert property (disable iff (1'b0) !rstn_in
		|=> pulse_count_low_r == RST_BYTE)
		else $error("count low byte not cleared by reset");
	count_high_rst_a: assert property (disable iff (1'b0) !rstn_in
		|=> pulse_count_high_r == RST_BYTE)
		else $error("count high byte not cleared by reset");
	// a disabled upper byte keeps whatever software left in it
	high_hold_a: assert property ((!upper_byte_enable && !wr_count_high)
		|=> $stable(pulse_count_high_r))
		else $error("disabled upper count byte changed");
	down_count_a: assert property ((low_end && !continuous && upper_byte_enable
		&& !wr_count_low && !wr_count_high && modulator_enable)
		|=> {pulse_count_high_r, pulse_count_low_r} == $past(count_dec))
		else $error("full count did not step down by one");
	low_write_start_a: assert property ((modulator_enable && state_r == IRPM_IDLE
		&& wr_count_low) |=> state_r == IRPM_LOW)
		else $error("count low write did not start the modulator");
	// the timer may only move on a tick or at the start of a burst
	timer_hold_a: assert property ((!mod_tick && !start)
		|=> $stable(pulse_timer_value_r))
		else $error("pulse timer moved without a modulation tick");
	// pin level follows the phase one cycle later, chopped only by the carrier
	steady_low_a: assert property ((state_r == IRPM_LOW && !carrier_modulate)
		|=> !port6_bit7_out)
		else $error("output not held low in an unmodulated low phase");
	chop_high_a: assert property ((state_r == IRPM_LOW && carrier_modulate
		&& !carrier_on) |=> port6_bit7_out)
		else $error("carrier did not chop the low phase");
	cont_run_a: assert property ((continuous && run && modulator_enable)
		|=> state_r != IRPM_DONE)
		else $error("continuous train came to an end");
	done_hold_a: assert property ((state_r == IRPM_DONE && modulator_enable)
		|=> state_r == IRPM_DONE)
		else $error("finished burst restarted without a disable");
endmodule // irpm_modulator

// ===== test/irpm_led.sv
`timescale 1ns/1ns
// -------------------------------------------------------------------------
// infrared led model
// -------------------------------------------------------------------------
module irpm_led (
	input wire logic core_clk_in,
	input wire logic clr_in,
	input wire logic pin_in,
	output logic [15:0] pulses_out,
	output logic [15:0] on_out,
	output logic [15:0] low_run_out,
	output logic [15:0] high_run_out
);
	logic [15:0] run_r;
	logic prev_r;

	// the led is lit while the pin sinks current, so low counts as on
	// run lengths are kept per edge; the first high run after a clear is meaningless
	always_ff @(posedge core_clk_in) begin
		if (clr_in) begin
			pulses_out <= 16'h0000;
			on_out <= 16'h0000;
			low_run_out <= 16'h0000;
			high_run_out <= 16'h0000;
			run_r <= 16'h0000;
			prev_r <= 1'b1;
		end else begin
			prev_r <= pin_in;
			run_r <= (pin_in !== prev_r) ? 16'h0001 : run_r + 16'h0001;
			if (pin_in === 1'b0) on_out <= on_out + 16'h0001;
			if (pin_in === 1'b0 && prev_r === 1'b1) begin
				pulses_out <= pulses_out + 16'h0001;
				high_run_out <= run_r;
			end
			if (pin_in === 1'b1 && prev_r === 1'b0) low_run_out <= run_r;
		end
	end
endmodule // irpm_led

// ===== test/infrared_pulse_modulator_bench.sv
`timescale 1ns/1ns
module infrared_pulse_modulator_bench;
	import irpm_pkg::*;
	logic clk, rstn, sp, wr_en, clr, port, irq;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, q;
	logic [15:0] pulses, on_cnt, low_run, high_run;
	int n_fail, cmp_count, i;
	logic [4:0] rtab [10] = '{5'h16, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h0b, 5'h0d, 5'h0f};
	logic [15:0] dv [4] = '{16'h1, 16'h1, 16'h4, 16'h8};
	logic [15:0] ex_on [4] = '{16'h6, 16'h4, 16'h3, 16'h6};

	irpm_modulator DUT (.core_clk_in(clk), .rstn_in(rstn), .reg_space_in(sp),
		.reg_addr_in(addr), .reg_wr_in(wr_en), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .port6_bit7_out(port), .burst_irq_out(irq));
	irpm_led led (.core_clk_in(clk), .clr_in(clr), .pin_in(port), .pulses_out(pulses),
		.on_out(on_cnt), .low_run_out(low_run), .high_run_out(high_run));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// -------------------------------------------------------------------------
	// access and checking tasks
	// -------------------------------------------------------------------------
	task complete_run;
		$display("mismatches %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one strobe cycle, released at the next edge so calls never overlap
	task wr(input logic s, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		sp <= s;
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// read data is registered, so it is taken one edge after the address
	task rd(input logic s, input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		sp <= s;
		addr <= a;
		@(posedge clk);
		#1 d = rdata;
	endtask

	task wait_irq;
		for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
		if (irq !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t burst never ended", $time);
			complete_run;
		end
		repeat (4) @(posedge clk);
	endtask

	// flag polling is needed where the interrupt is masked
	task wait_flag;
		q = 8'h00;
		for (int k = 0; k < 500 && q[0] !== 1'b1; k++) rd(1'b0, OFS_BURST_FLAG, q);
		if (q[0] !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t flag never set", $time);
			complete_run;
		end
	endtask

	// count is zeroed while disabled so enabling alone does not start a burst
	task burst(input logic [7:0] ctl, input logic [7:0] lo, input logic [7:0] hi,
		input logic [15:0] cnt, input bit wait_done);
		wr(1'b0, OFS_MODULATOR_CONTROL, 8'h00);
		wr(1'b0, OFS_BURST_FLAG, 8'h00);
		wr(1'b1, OFS_PULSE_COUNT_LOW, 8'h00);
		wr(1'b1, OFS_PULSE_COUNT_HIGH, 8'h00);
		wr(1'b1, OFS_LOW_PHASE_LENGTH, lo);
		wr(1'b1, OFS_HIGH_PHASE_LENGTH, hi);
		wr(1'b0, OFS_MODULATOR_CONTROL, ctl);
		wr(1'b1, OFS_PULSE_COUNT_HIGH, cnt[15:8]);
		clr <= 1'b1;
		wr(1'b1, OFS_PULSE_COUNT_LOW, cnt[7:0]);
		clr <= 1'b0;
		@(posedge clk);
		#1;
		if (!ctl[2]) chk({15'h0, port}, 16'h0);
		if (wait_done) wait_irq;
	endtask

	// -------------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		sp = 1'b0;
		addr = 4'h0;
		wr_en = 1'b0;
		wdata = 8'h00;
		clr = 1'b1;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		clr <= 1'b0;
		for (i = 0; i < 10; i++) begin
			rd(rtab[i][4], rtab[i][3:0], q);
			chk({8'h00, q}, 16'h0);
		end
		wr(1'b1, OFS_PULSE_COUNT_LOW, 8'ha5);
		rd(1'b1, OFS_PULSE_COUNT_LOW, q);
		chk({8'h00, q}, 16'h00a5);
		wr(1'b1, OFS_PULSE_COUNT_HIGH, 8'h5a);
		rd(1'b1, OFS_PULSE_COUNT_HIGH, q);
		chk({8'h00, q}, 16'h005a);
		wr(1'b1, OFS_COUNTER_CONTROL, 8'hff);
		rd(1'b1, OFS_COUNTER_CONTROL, q);
		chk({8'h00, q}, 16'h00f0);
		wr(1'b0, OFS_COUNTER_STATUS_ENABLES, 8'hff);
		rd(1'b0, OFS_COUNTER_STATUS_ENABLES, q);
		chk({8'h00, q}, 16'h0077);
		// count written while disabled must not start anything
		repeat (20) @(posedge clk);
		chk(pulses, 16'h0);
		chk({15'h0, port}, 16'h1);
		wr(1'b0, OFS_COUNTER_STATUS_ENABLES, 8'h40);
		wr(1'b1, OFS_COUNTER_CONTROL, 8'h10);
		burst(8'h08, 8'h03, 8'h05, 16'h0003, 1);
		chk(pulses, 16'h3);
		chk(low_run, 16'h3);
		chk(high_run, 16'h5);
		chk(on_cnt, 16'h9);
		chk({15'h0, port}, 16'h1);
		rd(1'b1, OFS_PULSE_COUNT_LOW, q);
		chk({8'h00, q}, 16'h0);
		burst(8'h08, 8'h01, 8'h01, 16'h0101, 1);
		chk(pulses, 16'h0101);
		wr(1'b1, OFS_COUNTER_CONTROL, 8'h00);
		burst(8'h08, 8'h01, 8'h01, 16'h0102, 1);
		chk(pulses, 16'h2);
		wr(1'b1, OFS_COUNTER_CONTROL, 8'h10);
		for (i = 0; i < 4; i++) begin
			burst({2'b00, i[1:0], 4'h8}, 8'h02, 8'h03, 16'h0002, 1);
			chk(low_run, dv[i] * 16'h2);
			chk(high_run, dv[i] * 16'h3);
		end
		burst(8'h0a, 8'h04, 8'h01, 16'h0003, 1);
		chk(pulses, 16'h1);
		chk(low_run, 16'hc);
		for (i = 0; i < 4; i++) begin
			burst({i[1:0], 6'h0e}, 8'h0c, 8'h01, 16'h0001, 1);
			chk(on_cnt, ex_on[i]);
		end
		burst(8'h4c, 8'h0c, 8'h02, 16'h0002, 1);
		chk(on_cnt, 16'h8);
		// masked interrupt: the flag still rises, the request does not
		wr(1'b0, OFS_COUNTER_STATUS_ENABLES, 8'h00);
		burst(8'h08, 8'h01, 8'h01, 16'h0002, 0);
		wait_flag;
		chk({15'h0, irq}, 16'h0);
		wr(1'b0, OFS_COUNTER_STATUS_ENABLES, 8'h40);
		burst(8'h09, 8'h02, 8'h02, 16'h0001, 0);
		repeat (100) @(posedge clk);
		chk({15'h0, irq}, 16'h0);
		chk({15'h0, pulses > 16'd20}, 16'h1);
		rd(1'b1, OFS_PULSE_COUNT_LOW, q);
		chk({8'h00, q}, 16'h1);
		wr(1'b0, OFS_MODULATOR_CONTROL, 8'h00);
		repeat (4) @(posedge clk);
		chk({15'h0, port}, 16'h1);
		complete_run;
	end
endmodule // infrared_pulse_modulator_bench
